// ===== logic/wwd_pkg.sv
// Package of the windowed watchdog: register offsets, control field positions,
// reset values and the prewarning span.
// Assumes an 8-bit special-function register port in front of the block.
package wwd_pkg;

   // Register offsets, valid only while the mapped register area is selected
   localparam logic [7:0] ADDR_CTRL   = 8'hbb;
   localparam logic [7:0] ADDR_RELOAD = 8'hbc;
   localparam logic [7:0] ADDR_WINB   = 8'hbd;
   localparam logic [7:0] ADDR_CNT_LO = 8'hbe;
   localparam logic [7:0] ADDR_CNT_HI = 8'hbf;

   // Control register field positions
   localparam int BIT_IN_SEL  = 0;
   localparam int BIT_REFRESH = 1;
   localparam int BIT_ENABLE  = 2;
   localparam int BIT_PREW    = 4;
   localparam int BIT_WIN_EN  = 5;

   // Values after reset
   localparam logic [7:0]  CTRL_RESET   = 8'h00;
   localparam logic [7:0]  RELOAD_RESET = 8'h00;
   localparam logic [7:0]  WINB_RESET   = 8'h00;
   localparam logic [15:0] CNT_RESET    = 16'h0000;
   localparam logic [7:0]  LOW_BYTE_ZERO = 8'h00;

   // Prewarning span in counter ticks
   localparam logic [5:0] PREW_SPAN = 6'h30;
   localparam logic [5:0] PREW_LAST = 6'h2f;

   // Prescaler ratios
   localparam int DIV_FAST = 2;
   localparam int DIV_SLOW = 128;

endpackage : wwd_pkg

// ===== logic/wwd_prescale.sv
// Prescaler of the watchdog: one tick every 2 or every 128 clocks.
// Assumes en and sel come from flip-flops of the watchdog core.
`timescale 1ns/1ps
module wwd_prescale #(
   parameter int DIV_FAST = wwd_pkg::DIV_FAST,
   parameter int DIV_SLOW = wwd_pkg::DIV_SLOW
) (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic clk_en,
   input  wire logic en,
   input  wire logic sel,
   output logic      tick
);
   localparam int W = $clog2(DIV_SLOW);

   typedef struct packed {
      logic [W-1:0] cnt;
   } wwd_pre_state_t;

   wwd_pre_state_t s_q;
   wwd_pre_state_t s_d;
   logic [W-1:0]   last;

   if (DIV_FAST < 2 || DIV_SLOW <= DIV_FAST || (DIV_SLOW & (DIV_SLOW - 1)) != 0
       || (DIV_FAST & (DIV_FAST - 1)) != 0)
   begin : g_ratio_check
      $error("wwd_prescale: ratios must be powers of two with 2 <= fast < slow");
   end

   assign last = sel ? W'(DIV_SLOW - 1) : W'(DIV_FAST - 1);
   // Masked compare so that switching ratio mid-count never waits a full wrap
   assign tick = clk_en && en && ((s_q.cnt & last) == last);

   always_comb
   begin
      s_d = s_q;
      // Restart from zero when stopped so the first period is always whole
      if (!en)
         s_d.cnt = '0;
      else
         s_d.cnt = s_q.cnt + W'(1);
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         s_q <= '0;
      else if (clk_en)
         s_q <= s_d;
   end

   property p_slow_spacing;
      @(posedge clk) disable iff (!arst_n)
      (tick && sel && en && clk_en) |=> !tick [*8];
   endproperty
   a_slow_spacing: assert property (p_slow_spacing) else $error("slow tick too soon");

   property p_fast_rate;
      @(posedge clk) disable iff (!arst_n)
      (tick && !sel && $stable(sel) && clk_en ##1 en && !sel && clk_en
         ##1 en && !sel && clk_en) |-> tick;
   endproperty
   a_fast_rate: assert property (p_fast_rate) else $error("fast tick not every 2 clocks");

endmodule : wwd_prescale

// ===== logic/wwd_readback.sv
// Read port of the watchdog registers: registered read data, one cycle latency.
// Assumes reads are strobes synchronous to clk; unmapped offsets read zero.
`timescale 1ns/1ps
module wwd_readback (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       clk_en,
   input  wire logic       rd,
   input  wire logic       map_sel,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] ctrl_byte,
   input  wire logic [7:0] reload,
   input  wire logic [7:0] winb,
   input  wire logic [15:0] count,
   output logic [7:0]      rdata
);
   typedef struct packed {
      logic [7:0] rdata;
   } wwd_rb_state_t;

   wwd_rb_state_t s_q;
   wwd_rb_state_t s_d;

   always_comb
   begin
      s_d = s_q;
      if (rd)
      begin
         if (!map_sel)
            s_d.rdata = 8'h00;
         else if (addr == wwd_pkg::ADDR_CTRL)
            s_d.rdata = ctrl_byte & 8'h37;
         else if (addr == wwd_pkg::ADDR_RELOAD)
            s_d.rdata = reload;
         else if (addr == wwd_pkg::ADDR_WINB)
            s_d.rdata = winb;
         else if (addr == wwd_pkg::ADDR_CNT_LO)
            s_d.rdata = count[7:0];
         else if (addr == wwd_pkg::ADDR_CNT_HI)
            s_d.rdata = count[15:8];
         else
            s_d.rdata = 8'h00;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         s_q <= '0;
      else if (clk_en)
         s_q <= s_d;
   end

   assign rdata = s_q.rdata;

   property p_count_read;
      @(posedge clk) disable iff (!arst_n)
      (rd && clk_en && map_sel && addr == wwd_pkg::ADDR_CNT_HI) |=> rdata == $past(count[15:8]);
   endproperty
   a_count_read: assert property (p_count_read) else $error("count high byte misread");

   property p_ctrl_layout;
      @(posedge clk) disable iff (!arst_n)
      (rd && clk_en && map_sel && addr == wwd_pkg::ADDR_CTRL)
         |=> rdata[7:6] == 2'b00 && rdata[3] == 1'b0;
   endproperty
   a_ctrl_layout: assert property (p_ctrl_layout) else $error("reserved control bits set");

endmodule : wwd_readback

// ===== logic/wwd_core.sv
// Windowed watchdog core: 16-bit up counter, window check, prewarning and reset.
// Assumes an 8-bit register port with one-cycle write and read strobes, all
// synchronous to clk, and a map select that qualifies every access.
`timescale 1ns/1ps
module wwd_core #(
   parameter int CNT_W = 16
) (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       clk_en,
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_wdata,
   input  wire logic       register_map_select,
   output logic [7:0]      sfr_rdata,
   output logic            timeout_nmi,
   output logic            system_reset_out
);

   if (CNT_W != 16)
   begin : g_width_check
      $error("wwd_core: counter must be 16 bits, high byte plus low byte");
   end

   typedef struct packed {
      logic                input_clock_select;
      logic                refresh_request;
      logic                counter_enable;
      logic                window_check_enable;
      logic                prewarning_flag;
      logic [7:0]          reload_high_byte;
      logic [7:0]          window_bound_value;
      logic [CNT_W-1:0]    watchdog_counter;
      logic [5:0]          prew_cnt;
      logic                nmi;
      logic                rst_out;
   } wwd_core_state_t;

   wwd_core_state_t s_q;
   wwd_core_state_t s_d;

   logic             tick;
   logic             wr_hit;
   logic             in_window;
   logic             svc_ok;
   logic             svc_bad;
   logic [CNT_W-1:0] bound;
   logic [CNT_W-1:0] reload_val;
   logic [7:0]       ctrl_byte;

   wwd_prescale #(
      .DIV_FAST (wwd_pkg::DIV_FAST),
      .DIV_SLOW (wwd_pkg::DIV_SLOW)
   ) u_prescale (
      .clk    (clk),
      .arst_n (arst_n),
      .clk_en (clk_en),
      .en     (s_q.counter_enable && !s_q.rst_out),
      .sel    (s_q.input_clock_select),
      .tick   (tick)
   );

   assign wr_hit     = sfr_wr && register_map_select;
   assign bound      = {s_q.window_bound_value, wwd_pkg::LOW_BYTE_ZERO};
   assign reload_val = {s_q.reload_high_byte, wwd_pkg::LOW_BYTE_ZERO};
   // Bound itself lies outside the window, so a zero bound never traps
   assign in_window  = s_q.watchdog_counter < bound;
   // A service is taken one cycle after the refresh bit is written
   assign svc_bad    = s_q.refresh_request && !s_q.prewarning_flag
                       && s_q.window_check_enable && in_window;
   assign svc_ok     = s_q.refresh_request && !s_q.prewarning_flag && !svc_bad;

   always_comb
   begin
      s_d         = s_q;
      s_d.nmi     = 1'b0;
      s_d.rst_out = 1'b0;
      if (s_q.rst_out)
      begin
         s_d = '0;
      end
      else
      begin
         if (tick)
         begin
            s_d.watchdog_counter = s_q.watchdog_counter + CNT_W'(1);
            if (s_q.prewarning_flag)
            begin
               s_d.prew_cnt = s_q.prew_cnt + 6'h01;
               if (s_q.prew_cnt == wwd_pkg::PREW_LAST)
                  s_d.rst_out = 1'b1;
            end
            // A service taken in the same cycle beats the overflow
            else if (&s_q.watchdog_counter && !svc_ok)
            begin
               s_d.prewarning_flag = 1'b1;
               s_d.nmi             = 1'b1;
            end
         end
         if (s_q.refresh_request)
            s_d.refresh_request = 1'b0;
         if (svc_bad)
            s_d.prewarning_flag = 1'b1;
         if (svc_ok)
            s_d.watchdog_counter = reload_val;
         if (wr_hit)
         begin
            if (sfr_addr == wwd_pkg::ADDR_CTRL)
            begin
               s_d.input_clock_select  = sfr_wdata[wwd_pkg::BIT_IN_SEL];
               s_d.counter_enable      = sfr_wdata[wwd_pkg::BIT_ENABLE];
               s_d.window_check_enable = sfr_wdata[wwd_pkg::BIT_WIN_EN];
               // Software set wins over the hardware clear above
               if (sfr_wdata[wwd_pkg::BIT_REFRESH])
                  s_d.refresh_request = 1'b1;
            end
            else if (sfr_addr == wwd_pkg::ADDR_RELOAD)
               s_d.reload_high_byte = sfr_wdata;
            else if (sfr_addr == wwd_pkg::ADDR_WINB)
               s_d.window_bound_value = sfr_wdata;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_q                    <= '0;
         s_q.reload_high_byte   <= wwd_pkg::RELOAD_RESET;
         s_q.window_bound_value <= wwd_pkg::WINB_RESET;
         s_q.watchdog_counter   <= wwd_pkg::CNT_RESET;
      end
      else if (clk_en)
         s_q <= s_d;
   end

   assign ctrl_byte = {2'b00, s_q.window_check_enable, s_q.prewarning_flag, 1'b0,
                       s_q.counter_enable, s_q.refresh_request, s_q.input_clock_select};

   wwd_readback u_readback (
      .clk       (clk),
      .arst_n    (arst_n),
      .clk_en    (clk_en),
      .rd        (sfr_rd),
      .map_sel   (register_map_select),
      .addr      (sfr_addr),
      .ctrl_byte (ctrl_byte),
      .reload    (s_q.reload_high_byte),
      .winb      (s_q.window_bound_value),
      .count     (s_q.watchdog_counter),
      .rdata     (sfr_rdata)
   );

   assign timeout_nmi      = s_q.nmi;
   assign system_reset_out = s_q.rst_out;

   // Checks

   sequence s_overflow;
      tick && !s_q.prewarning_flag && &s_q.watchdog_counter && !s_q.refresh_request
         && !s_q.rst_out;
   endsequence

   sequence s_last_prew_tick;
      tick && s_q.prewarning_flag && s_q.prew_cnt == 6'h2f && !s_q.rst_out;
   endsequence

   property p_nmi_on_overflow;
      @(posedge clk) disable iff (!arst_n)
      s_overflow |=> timeout_nmi && s_q.prewarning_flag && s_q.watchdog_counter == 16'h0000;
   endproperty
   a_nmi_on_overflow: assert property (p_nmi_on_overflow) else $error("no nmi on overflow");

   property p_nmi_cause;
      @(posedge clk) disable iff (!arst_n)
      $rose(timeout_nmi) |-> $past(tick) && $past(&s_q.watchdog_counter) && s_q.prewarning_flag;
   endproperty
   a_nmi_cause: assert property (p_nmi_cause) else $error("nmi without overflow");

   property p_reset_after_span;
      @(posedge clk) disable iff (!arst_n)
      s_last_prew_tick |=> system_reset_out ##1 s_q.watchdog_counter == 16'h0000;
   endproperty
   a_reset_after_span: assert property (p_reset_after_span) else $error("late reset");

   property p_no_early_reset;
      @(posedge clk) disable iff (!arst_n)
      $rose(system_reset_out) |-> $past(s_q.prew_cnt) == 6'h2f && $past(s_q.prewarning_flag);
   endproperty
   a_no_early_reset: assert property (p_no_early_reset) else $error("early reset");

   property p_invalid_refresh;
      @(posedge clk) disable iff (!arst_n)
      (clk_en && svc_bad && !s_q.rst_out) |=> s_q.prewarning_flag && !timeout_nmi
         && s_q.prew_cnt == 6'h00;
   endproperty
   a_invalid_refresh: assert property (p_invalid_refresh) else $error("window miss");

   property p_window_bound;
      @(posedge clk) disable iff (!arst_n)
      (clk_en && s_q.refresh_request && !s_q.prewarning_flag && s_q.window_check_enable
         && s_q.watchdog_counter >= bound && !s_q.rst_out)
         |=> s_q.watchdog_counter == $past(reload_val) && !s_q.prewarning_flag;
   endproperty
   a_window_bound: assert property (p_window_bound) else $error("refresh above bound refused");

   property p_window_off;
      @(posedge clk) disable iff (!arst_n)
      (clk_en && s_q.refresh_request && !s_q.prewarning_flag && !s_q.window_check_enable
         && !s_q.rst_out) |=> !s_q.prewarning_flag && !s_q.refresh_request;
   endproperty
   a_window_off: assert property (p_window_off) else $error("window check while disabled");

   property p_reload;
      @(posedge clk) disable iff (!arst_n)
      (clk_en && svc_ok && !s_q.rst_out) |=> s_q.watchdog_counter[7:0] == 8'h00
         && s_q.watchdog_counter[15:8] == $past(s_q.reload_high_byte);
   endproperty
   a_reload: assert property (p_reload) else $error("bad reload value");

   property p_map_select;
      @(posedge clk) disable iff (!arst_n)
      (clk_en && sfr_wr && !register_map_select && !s_q.rst_out)
         |=> $stable(s_q.reload_high_byte) && $stable(s_q.window_bound_value);
   endproperty
   a_map_select: assert property (p_map_select) else $error("write without map select");

   property p_stopped;
      @(posedge clk) disable iff (!arst_n)
      (!s_q.counter_enable && !s_q.refresh_request ##1 !s_q.counter_enable)
         |-> $stable(s_q.watchdog_counter);
   endproperty
   a_stopped: assert property (p_stopped) else $error("counting while disabled");

   property p_prew_sticky;
      @(posedge clk) disable iff (!arst_n)
      (s_q.prewarning_flag && !s_q.rst_out) |=> s_q.prewarning_flag;
   endproperty
   a_prew_sticky: assert property (p_prew_sticky) else $error("prewarning flag dropped");

   property p_wdt_reset_clears;
      @(posedge clk) disable iff (!arst_n)
      (system_reset_out && clk_en) |=> ctrl_byte == 8'h00 && s_q.reload_high_byte == 8'h00
         && s_q.window_bound_value == 8'h00 && s_q.watchdog_counter == 16'h0000;
   endproperty
   a_wdt_reset_clears: assert property (p_wdt_reset_clears) else $error("reset left state");

   sequence s_refresh_retired;
      clk_en && s_q.refresh_request && !s_q.rst_out
         && !(wr_hit && sfr_addr == wwd_pkg::ADDR_CTRL && sfr_wdata[wwd_pkg::BIT_REFRESH]);
   endsequence

   // A stuck refresh bit would service the counter forever and mask a hung program
   property p_refresh_clear;
      @(posedge clk) disable iff (!arst_n)
      s_refresh_retired |=> !s_q.refresh_request;
   endproperty
   a_refresh_clear: assert property (p_refresh_clear) else $error("refresh stuck");

   property p_nmi_one_cycle;
      @(posedge clk) disable iff (!arst_n)
      (timeout_nmi && clk_en) |=> !timeout_nmi;
   endproperty
   a_nmi_one_cycle: assert property (p_nmi_one_cycle) else $error("nmi held");

   property p_reset_one_cycle;
      @(posedge clk) disable iff (!arst_n)
      (system_reset_out && clk_en) |=> !system_reset_out;
   endproperty
   a_reset_one_cycle: assert property (p_reset_one_cycle) else $error("reset held");

   property p_prew_entry;
      @(posedge clk) disable iff (!arst_n)
      $rose(s_q.prewarning_flag) |-> s_q.prew_cnt == 6'h00 && !system_reset_out;
   endproperty
   a_prew_entry: assert property (p_prew_entry) else $error("late prewarning entry");

   property p_count_ro;
      @(posedge clk) disable iff (!arst_n)
      (clk_en && wr_hit && sfr_addr >= wwd_pkg::ADDR_CNT_LO && !tick && !svc_ok
         && !s_q.rst_out) |=> $stable(s_q.watchdog_counter);
   endproperty
   a_count_ro: assert property (p_count_ro) else $error("count written");

   property p_tick_gated;
      @(posedge clk) disable iff (!arst_n)
      tick |-> s_q.counter_enable && clk_en && !s_q.rst_out;
   endproperty
   a_tick_gated: assert property (p_tick_gated) else $error("stray tick");

   property p_count_step;
      @(posedge clk) disable iff (!arst_n)
      (tick && !svc_ok && !s_q.rst_out)
         |=> s_q.watchdog_counter == $past(s_q.watchdog_counter) + 16'h0001;
   endproperty
   a_count_step: assert property (p_count_step) else $error("count did not step");

endmodule : wwd_core

// ===== testbench/windowed_watchdog_timer_tb.sv
// Self-checking bench of the windowed watchdog core: register access, service,
// window check, overflow, prewarning and the watchdog reset.
// Assumes wwd_pkg and wwd_core are compiled first; one 10 MHz clock.
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
   $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end
module windowed_watchdog_timer_tb;
   logic       clk;
   logic       arst_n;
   logic       clk_en;
   logic [7:0] sfr_addr;
   logic       sfr_wr;
   logic       sfr_rd;
   logic [7:0] sfr_wdata;
   logic       register_map_select;
   logic [7:0] sfr_rdata;
   logic       timeout_nmi;
   logic       system_reset_out;
   int         fails;
   int         samples_checked;
   int         cyc;
   int         t_nmi;
   int         t_rst;
   int         nmi_cnt;
   int         n;
   logic [7:0] rv;
   logic [7:0] d2;

   wwd_core DUT (
      .clk                 (clk),
      .arst_n              (arst_n),
      .clk_en              (clk_en),
      .sfr_addr            (sfr_addr),
      .sfr_wr              (sfr_wr),
      .sfr_rd              (sfr_rd),
      .sfr_wdata           (sfr_wdata),
      .register_map_select (register_map_select),
      .sfr_rdata           (sfr_rdata),
      .timeout_nmi         (timeout_nmi),
      .system_reset_out    (system_reset_out)
   );

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Pulses are one cycle wide, so record them at every edge rather than polling
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (timeout_nmi === 1'b1)
      begin
         t_nmi   <= cyc;
         nmi_cnt <= nmi_cnt + 1;
      end
      if (system_reset_out === 1'b1)
         t_rst <= cyc;
   end

   task automatic complete_run;
      $display("checks %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : complete_run

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic m = 1'b1);
      @(negedge clk);
      sfr_addr            = a;
      sfr_wdata           = d;
      register_map_select = m;
      sfr_wr              = 1'b1;
      @(negedge clk);
      sfr_wr              = 1'b0;
      register_map_select = 1'b1;
   endtask : wr

   // Read data is registered: it is valid one cycle after the strobe edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d, input logic m = 1'b1);
      @(negedge clk);
      sfr_addr            = a;
      register_map_select = m;
      sfr_rd              = 1'b1;
      @(negedge clk);
      sfr_rd              = 1'b0;
      register_map_select = 1'b1;
      d                   = sfr_rdata;
   endtask : rd

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      `CHK(d, e)
   endtask : rd_chk

   task automatic wait_hi(input int which, input int limit, output int cnt);
      cnt = 0;
      while (((which == 0) ? timeout_nmi : system_reset_out) !== 1'b1)
      begin
         @(negedge clk);
         cnt++;
         if (cnt > limit)
         begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, cnt, limit);
            complete_run();
         end
      end
   endtask : wait_hi

   task automatic all_zero;
      for (int a = 8'hbb; a <= 8'hbf; a++)
         rd_chk(a[7:0], 8'h00);
   endtask : all_zero

   initial
   begin
      fails = 0;
      samples_checked = 0;
      arst_n = 1'b0;
      clk_en = 1'b1;
      sfr_addr = 8'h00;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      sfr_wdata = 8'h00;
      register_map_select = 1'b1;
      repeat (10) @(negedge clk);
      arst_n = 1'b1;

      all_zero();
      // Map select low hides every watchdog register
      wr(wwd_pkg::ADDR_RELOAD, 8'h5a, 1'b0);
      rd(wwd_pkg::ADDR_RELOAD, rv, 1'b0);
      `CHK(rv, 8'h00)
      rd_chk(wwd_pkg::ADDR_RELOAD, 8'h00);
      wr(wwd_pkg::ADDR_CNT_LO, 8'ha5);
      wr(wwd_pkg::ADDR_CNT_HI, 8'h5a);
      rd_chk(wwd_pkg::ADDR_CNT_LO, 8'h00);
      rd_chk(wwd_pkg::ADDR_CNT_HI, 8'h00);
      rd_chk(8'hba, 8'h00);
      wr(wwd_pkg::ADDR_CTRL, 8'hfd);
      rd_chk(wwd_pkg::ADDR_CTRL, 8'h25);
      wr(wwd_pkg::ADDR_CTRL, 8'h00);
      wr(wwd_pkg::ADDR_WINB, 8'hc3);
      rd_chk(wwd_pkg::ADDR_WINB, 8'hc3);

      // Overflow at divide by 2, then prewarning and reset
      wr(wwd_pkg::ADDR_RELOAD, 8'hff);
      rd_chk(wwd_pkg::ADDR_RELOAD, 8'hff);
      wr(wwd_pkg::ADDR_WINB, 8'h00);
      wr(wwd_pkg::ADDR_CTRL, 8'h04);
      wr(wwd_pkg::ADDR_CTRL, 8'h06);
      rd_chk(wwd_pkg::ADDR_CNT_HI, 8'hff);
      rd_chk(wwd_pkg::ADDR_CTRL, 8'h04);
      wait_hi(0, 700, n);
      `CHK((n >= 480 && n <= 520), 1'b1)
      @(negedge clk);
      `CHK(timeout_nmi, 1'b0)
      rd_chk(wwd_pkg::ADDR_CTRL, 8'h14);
      wait_hi(1, 200, n);
      @(negedge clk);
      `CHK(t_rst - t_nmi, 96)
      `CHK(nmi_cnt, 1)
      all_zero();
      repeat (20) @(negedge clk);
      rd_chk(wwd_pkg::ADDR_CNT_LO, 8'h00);

      // Window disabled: a refresh near zero is valid
      wr(wwd_pkg::ADDR_WINB, 8'hff);
      wr(wwd_pkg::ADDR_CTRL, 8'h04);
      wr(wwd_pkg::ADDR_CTRL, 8'h06);
      repeat (4) @(negedge clk);
      rd_chk(wwd_pkg::ADDR_CTRL, 8'h04);
      // Clock enable low freezes counter and prescaler: only 3 live edges span the reads
      rd(wwd_pkg::ADDR_CNT_LO, rv);
      @(negedge clk);
      clk_en = 1'b0;
      repeat (20) @(negedge clk);
      clk_en = 1'b1;
      rd(wwd_pkg::ADDR_CNT_LO, d2);
      `CHK((d2 - rv >= 8'h01 && d2 - rv <= 8'h02), 1'b1)
      // Asynchronous reset in mid-run clears everything the bus can see
      arst_n = 1'b0;
      @(negedge clk);
      arst_n = 1'b1;
      all_zero();
      wr(wwd_pkg::ADDR_WINB, 8'hff);
      // Count one above the bound value lies outside the window
      wr(wwd_pkg::ADDR_RELOAD, 8'hff);
      wr(wwd_pkg::ADDR_CTRL, 8'h06);
      wr(wwd_pkg::ADDR_CTRL, 8'h26);
      repeat (4) @(negedge clk);
      rd_chk(wwd_pkg::ADDR_CTRL, 8'h24);
      rd_chk(wwd_pkg::ADDR_CNT_HI, 8'hff);
      // Refresh deep inside the window: prewarning without interrupt
      wr(wwd_pkg::ADDR_RELOAD, 8'h00);
      wr(wwd_pkg::ADDR_CTRL, 8'h26);
      wr(wwd_pkg::ADDR_CTRL, 8'h26);
      repeat (2) @(negedge clk);
      rd_chk(wwd_pkg::ADDR_CTRL, 8'h34);
      wait_hi(1, 200, n);
      `CHK((n >= 80 && n <= 100), 1'b1)
      @(negedge clk);
      `CHK(nmi_cnt, 1)
      all_zero();

      // Divide by 128 sets both the overflow period and the prewarning span
      wr(wwd_pkg::ADDR_RELOAD, 8'hff);
      wr(wwd_pkg::ADDR_CTRL, 8'h05);
      wr(wwd_pkg::ADDR_CTRL, 8'h07);
      wait_hi(0, 33500, n);
      `CHK((n >= 32600 && n <= 32900), 1'b1)
      wait_hi(1, 7000, n);
      @(negedge clk);
      `CHK(t_rst - t_nmi, 6144)
      `CHK(nmi_cnt, 2)
      all_zero();
      complete_run();
   end
endmodule : windowed_watchdog_timer_tb
